// ### slcr_host_model.sv
// Host stand-in: single register strobes launched at the falling edge.
// Assumes the bank samples strobes on the rising edge of clk.
module slcr_host_model (
	// Clock and strobes
	input logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0_0000;
	// One strobe cycle, then idle with scrambled address and data
	task automatic xfer(input logic w, input logic [7:0] a, d);
		@(negedge clk);
		{reg_addr, reg_wr, reg_wdata, reg_rd} = {a, w, d, !w};
		@(negedge clk);
		{reg_addr, reg_wr, reg_wdata, reg_rd} = {~a, 1'b0, ~d, 1'b0};
	endtask
endmodule // slcr_host_model

// ### slcr_regbank.v
// Byte-addressed register bank: upper impedance selects, input receiver setup,
// permanent and clearable write guards, sticky signal-loss events.
// Assumes an SMBus engine on clk presenting one-cycle read and write strobes.
`include "slcr_regs.vh"

// Operation
// - Byte 0x15 bits 4..0 pick 85 or 100 ohm drive for outputs 8..12.
// - Receiver byte bit 3 and bit 1 pick AC coupling bias for inputs b, a.
// - Receiver byte bit 2 and bit 0 enable termination; bits 7..4 read zero.
// - Writing one to byte 0x26 bit 0 sets a permanent write guard.
// - Permanent guard never clears by write, only by power-on reset.
// - Byte 0x27 bit 0 is a guard set by one, cleared by one again.
// - Control writes accepted only while both guard bits are zero.
// - Byte 0x27 bits 2 and 1 latch bank 1 and bank 0 signal loss.
// - Writing one clears only that event flag; zeros leave flags alone.
// - Byte 0x27 bits 7..3 reserved, zero; bytes 0x16-0x22 and 0x25 reserved.
module slcr_regbank #(
	parameter IMP_W = `SLCR_IMP_W
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Register access from SMBus engine
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Impedance strap, asynchronous pin
	input wire [IMP_W-1:0] imp_strap,
	// Loss detector levels, asynchronous, high while signal lost
	input wire bank0_signal_loss,
	input wire bank1_signal_loss,
	// Impedance selects, 0 = 85 ohm, 1 = 100 ohm
	output reg out8_drive_impedance_sel,
	output reg out9_drive_impedance_sel,
	output reg out10_drive_impedance_sel,
	output reg out11_drive_impedance_sel,
	output reg out12_drive_impedance_sel,
	// Receiver controls
	output reg input0_ac_bias_enable,
	output reg input1_ac_bias_enable,
	output reg input0_termination_enable,
	output reg input1_termination_enable,
	// Guard status
	output reg write_blocked
);
	// ====================================
	// Synchronise pins
	wire [IMP_W-1:0] strap_s;
	wire [1:0] loss_s;

	slcr_sync2 #(.W(IMP_W)) u_strap_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(imp_strap),
		.q(strap_s)
	);

	slcr_sync2 #(.W(2)) u_loss_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d({bank1_signal_loss, bank0_signal_loss}),
		.q(loss_s)
	);

	// ====================================
	// State
	reg [1:0] strap_cnt_q;
	reg [IMP_W-1:0] imp_q;
	reg [`SLCR_RX_W-1:0] rx_q;
	reg perm_q;
	reg guard_q;
	reg [1:0] evt_q;
	reg [1:0] evt_d;
	wire strap_load;
	wire wr_ok;
	wire wr_imp;
	wire wr_rx;
	wire wr_perm;
	wire wr_evt;

	// Strap is caught once the synchroniser has settled after release
	assign strap_load = (strap_cnt_q == 2'd2);
	assign wr_ok = reg_wr && !perm_q && !guard_q;
	assign wr_imp = wr_ok && (reg_addr == `SLCR_OFS_IMP_UPPER);
	assign wr_rx = wr_ok && (reg_addr == `SLCR_OFS_RX_CFG);
	assign wr_perm = wr_ok && (reg_addr == `SLCR_OFS_PERM_GUARD);
	assign wr_evt = reg_wr && (reg_addr == `SLCR_OFS_GUARD_EVT);

	// Strap capture counter
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_cnt_q <= 2'd0;
		end else if (strap_cnt_q != 2'd3) begin
			strap_cnt_q <= strap_cnt_q + 2'd1;
		end
	end

	// Impedance selects: strap first, then writes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			imp_q <= {IMP_W{1'b0}};
		end else if (strap_load) begin
			imp_q <= strap_s;
		end else if (wr_imp) begin
			imp_q <= reg_wdata[IMP_W-1:0];
		end
	end

	// Receiver coupling and termination
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_q <= `SLCR_RX_RST;
		end else if (wr_rx) begin
			rx_q <= reg_wdata[`SLCR_RX_W-1:0];
		end
	end

	// Permanent guard, cleared only by reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			perm_q <= 1'b0;
		end else if (wr_perm && reg_wdata[`SLCR_PERM_BIT]) begin
			perm_q <= 1'b1;
		end
	end

	// Clearable guard toggles on a one; write reaches it even while locked
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			guard_q <= 1'b0;
		end else if (wr_evt && reg_wdata[`SLCR_GUARD_BIT]) begin
			guard_q <= ~guard_q;
		end
	end

	// Sticky events: set wins over a same-cycle clear
	always @* begin
		evt_d = evt_q;
		if (wr_evt) begin
			evt_d = evt_q & ~reg_wdata[`SLCR_LOS1_BIT:`SLCR_LOS0_BIT];
		end
		evt_d = evt_d | loss_s;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_q <= 2'b00;
		end else begin
			evt_q <= evt_d;
		end
	end

	// Read data, reserved and unmapped read zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `SLCR_RD_NONE;
		end else if (reg_rd) begin
			case (reg_addr)
				`SLCR_OFS_IMP_UPPER: reg_rdata <= {{(8-IMP_W){1'b0}}, imp_q};
				`SLCR_OFS_RX_CFG: reg_rdata <= {4'h0, rx_q};
				`SLCR_OFS_PERM_GUARD: reg_rdata <= {7'h00, perm_q};
				`SLCR_OFS_GUARD_EVT: reg_rdata <= {5'h00, evt_q, guard_q};
				default: reg_rdata <= `SLCR_RD_NONE;
			endcase
		end
	end

	// Registered outputs
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out8_drive_impedance_sel <= 1'b0;
			out9_drive_impedance_sel <= 1'b0;
			out10_drive_impedance_sel <= 1'b0;
			out11_drive_impedance_sel <= 1'b0;
			out12_drive_impedance_sel <= 1'b0;
			input0_termination_enable <= 1'b0;
			input0_ac_bias_enable <= 1'b0;
			input1_termination_enable <= 1'b0;
			input1_ac_bias_enable <= 1'b0;
			write_blocked <= 1'b0;
		end else begin
			out8_drive_impedance_sel <= imp_q[0];
			out9_drive_impedance_sel <= imp_q[1];
			out10_drive_impedance_sel <= imp_q[2];
			out11_drive_impedance_sel <= imp_q[3];
			out12_drive_impedance_sel <= imp_q[4];
			input0_termination_enable <= rx_q[`SLCR_INPUT0_TERMINATION_ENABLE];
			input0_ac_bias_enable <= rx_q[`SLCR_RX_AC0];
			input1_termination_enable <= rx_q[`SLCR_INPUT1_TERMINATION_ENABLE];
			input1_ac_bias_enable <= rx_q[`SLCR_RX_AC1];
			write_blocked <= perm_q | guard_q;
		end
	end
endmodule // slcr_regbank

// ### slcr_regbank_checker.sv
// Checker for the register bank: guard timing, receiver pin, read answers.
// Assumes it is bound into slcr_regbank with ports matched by name.
module slcr_regbank_checker (
	// Clock, reset and strobes
	input logic clk,
	input logic rst_b,
	input logic [7:0] reg_addr,
	input logic reg_wr,
	input logic [7:0] reg_wdata,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	// Loss input and observed levels
	input logic bank1_signal_loss,
	input logic input0_termination_enable,
	input logic write_blocked
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// Decoded write strobes
	wire wr23 = reg_wr && reg_addr == 8'h23;
	wire wr26 = reg_wr && reg_addr == 8'h26 && reg_wdata[0];
	wire wr27 = reg_wr && reg_addr == 8'h27 && reg_wdata[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_rx_wr; wr23 && !write_blocked ##1 !write_blocked
		|=> input0_termination_enable == $past(reg_wdata[0], 2); endproperty
	a_rx_wr: assert property (p_rx_wr) else $error("rx write lost");
	property p_rx_blk; wr23 && write_blocked ##1 write_blocked
		|=> $stable(input0_termination_enable); endproperty
	a_rx_blk: assert property (p_rx_blk) else $error("blocked write taken");
	property p_perm; wr26 && !write_blocked ##1 !write_blocked |-> ##[1:2] write_blocked; endproperty
	a_perm: assert property (p_perm) else $error("lock not set");
	property p_guard; wr27 && !write_blocked ##1 !write_blocked |-> ##[1:2] write_blocked; endproperty
	a_guard: assert property (p_guard) else $error("guard not set");
	property p_lock_rd; reg_rd && reg_addr == 8'h26 |=> !reg_rdata[0] || write_blocked; endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("lock not blocking");
	property p_rsv; reg_rd && reg_addr inside {[8'h16:8'h22], 8'h25} |=> reg_rdata == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved read");
	property p_evt_rsv; reg_rd && reg_addr == 8'h27 |=> reg_rdata[7:3] == 5'h00; endproperty
	a_evt_rsv: assert property (p_evt_rsv) else $error("event spare bits");
	property p_los1; bank1_signal_loss [*4] ##1 reg_rd && reg_addr == 8'h27 |=> reg_rdata[2];
	endproperty
	a_los1: assert property (p_los1) else $error("loss not latched");
endmodule // slcr_regbank_checker

// ### slcr_regbank_tb_top.sv
// Bench for the register bank: host model drives, reads are checked from a queue.
// Assumes the host model and checker are compiled first.
module slcr_regbank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, l0 = 0, l1 = 0, rd_d = 0, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rx, imp;
	logic [4:0] st, imp_pin;
	logic [3:0] rx_pin;
	logic wb_pin;
	logic [7:0] expq[$];
	int n_mismatch = 0, cmp_count = 0;
	// Clock, host and design
	initial forever #25 clk = ~clk;
	slcr_host_model host_u (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
	slcr_regbank dut_u (.clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.imp_strap(st), .bank0_signal_loss(l0), .bank1_signal_loss(l1),
		.out8_drive_impedance_sel(imp_pin[0]), .out9_drive_impedance_sel(imp_pin[1]),
		.out10_drive_impedance_sel(imp_pin[2]), .out11_drive_impedance_sel(imp_pin[3]),
		.out12_drive_impedance_sel(imp_pin[4]), .write_blocked(wb_pin),
		.input0_ac_bias_enable(rx_pin[1]), .input1_ac_bias_enable(rx_pin[3]),
		.input0_termination_enable(rx_pin[0]), .input1_termination_enable(rx_pin[2]));
	// Pin levels against the expected register contents
	task automatic pins(input logic [4:0] ei, input logic [3:0] er, input logic eb);
		cmp_count++;
		if ({imp_pin, rx_pin, wb_pin} !== {ei, er, eb}) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, {imp_pin, rx_pin, wb_pin}, {ei, er, eb});
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		host_u.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, e);
		expq.push_back(e);
		host_u.xfer(1'b0, a, 8'h00);
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Read answers against the oldest expectation
	always @(posedge clk) rd_d <= reg_rd;
	always @(negedge clk) if (rd_d) begin
		cmp_count++;
		if (reg_rdata !== expq[0]) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, reg_rdata, expq[0]);
		end
		void'(expq.pop_front());
	end
	// Hang guard
	initial begin
		#100us;
		n_mismatch++;
		summarize();
	end
	// Main sequence
	initial begin
		st = 5'($urandom(32'hf680_03b8));
		repeat (3) @(negedge clk);
		rst_b = 1;
		repeat (5) @(negedge clk);
		rd(8'h15, {3'h0, st});
		pins(st, 4'h0, 1'b0);
		imp = {3'h0, 5'($urandom)};
		wr(8'h15, imp);
		rd(8'h15, imp);
		pins(imp[4:0], 4'h0, 1'b0);
		rx = {4'h0, 4'($urandom)};
		wr(8'h23, rx | 8'hf0);
		rd(8'h23, rx);
		pins(imp[4:0], rx[3:0], 1'b0);
		for (int a = 8'h16; a < 8'h26; a++) begin
			wr(8'(a), 8'hff);
			if (a != 8'h23) rd(8'(a), 8'h00);
			else rd(8'(a), {4'h0, 4'hf});
		end
		rx = 8'h0f;
		l1 = 1;
		repeat (4) @(negedge clk);
		rd(8'h27, 8'h04);
		l1 = 0;
		l0 = 1;
		repeat (4) @(negedge clk);
		rd(8'h27, 8'h06);
		l0 = 0;
		wr(8'h27, 8'h04);
		rd(8'h27, 8'h02);
		wr(8'h27, 8'hfa);
		rd(8'h27, 8'h00);
		wr(8'h27, 8'h01);
		rd(8'h27, 8'h01);
		pins(imp[4:0], 4'hf, 1'b1);
		wr(8'h23, 8'h00);
		rd(8'h23, rx);
		wr(8'h27, 8'h01);
		rd(8'h27, 8'h00);
		wr(8'h26, 8'h01);
		wr(8'h26, 8'h00);
		rd(8'h26, 8'h01);
		wr(8'h15, ~imp);
		rd(8'h15, imp);
		pins(imp[4:0], 4'hf, 1'b1);
		wr(8'h27, 8'h01);
		wr(8'h27, 8'h01);
		wr(8'h23, 8'h00);
		rd(8'h23, rx);
		rst_b = 0;
		repeat (3) @(negedge clk);
		rst_b = 1;
		repeat (5) @(negedge clk);
		rd(8'h26, 8'h00);
		rd(8'h23, 8'h00);
		pins(st, 4'h0, 1'b0);
		repeat (3) @(negedge clk);
		summarize();
	end
endmodule // slcr_regbank_tb_top
bind slcr_regbank slcr_regbank_checker chk_u (.*);

// ### slcr_regs.vh
// Constants for the impedance, receiver, write-guard and signal-loss register bank.
// Assumes byte addresses and 8-bit data from an SMBus engine on the same clock.
`ifndef SLCR_REGS_VH
`define SLCR_REGS_VH
// ====================================
// Register byte offsets
`define SLCR_OFS_IMP_UPPER 8'h15
`define SLCR_OFS_RSV_LO 8'h16
`define SLCR_OFS_RSV_HI 8'h22
`define SLCR_OFS_RX_CFG 8'h23
`define SLCR_OFS_RSV_37 8'h25
`define SLCR_OFS_PERM_GUARD 8'h26
`define SLCR_OFS_GUARD_EVT 8'h27
// ====================================
// Field positions
`define SLCR_IMP_W 5
`define SLCR_INPUT0_TERMINATION_ENABLE 0
`define SLCR_RX_AC0 1
`define SLCR_INPUT1_TERMINATION_ENABLE 2
`define SLCR_RX_AC1 3
`define SLCR_RX_W 4
`define SLCR_PERM_BIT 0
`define SLCR_GUARD_BIT 0
`define SLCR_LOS0_BIT 1
`define SLCR_LOS1_BIT 2
// ====================================
// Reset values
`define SLCR_RX_RST 4'h0
`define SLCR_EVT_RST 8'h00
`define SLCR_RD_NONE 8'h00
`endif

// ### slcr_sync2.v
// Two-stage synchroniser for asynchronous level inputs.
// Assumes the inputs are levels held for several clock periods.
module slcr_sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Data
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;

	// Only the second stage reads the first
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // slcr_sync2
